// ==== rtl/icbi_pkg.sv ====
package icbi_pkg;

   // ---------------------------------------------------------------
   // clocking and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned TICK_HZ       = 15;
   localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;
   localparam int unsigned ACK_WAIT_CYC  = 64;

   // ---------------------------------------------------------------
   // bus addresses
   // ---------------------------------------------------------------
   localparam logic [7:0]  TICK_ADDR     = 8'h0f;
   localparam logic [7:0]  REFRESH_RST   = 8'h08;
   localparam logic [7:0]  LOAD_ADDR_RST = 8'h01;
   localparam logic [2:0]  LOAD_SLOT_RST = 3'h1;

   // ---------------------------------------------------------------
   // operation classes
   // ---------------------------------------------------------------
   localparam logic [1:0]  OP_TEST       = 2'b00;
   localparam logic [1:0]  OP_CONTROL    = 2'b01;
   localparam logic [1:0]  OP_READ       = 2'b10;
   localparam logic [1:0]  OP_WRITE      = 2'b11;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_CMD       = 12'h000;
   localparam logic [11:0] OFF_STATUS    = 12'h004;
   localparam logic [11:0] OFF_CONFIG    = 12'h008;
   localparam logic [11:0] OFF_INT_MAP   = 12'h00c;
   localparam logic [11:0] OFF_IRQ_STAT  = 12'h010;
   localparam logic [11:0] OFF_IRQ_MASK  = 12'h014;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CMD_ADDR_LSB  = 0;
   localparam int unsigned CMD_OP_LSB    = 8;
   localparam int unsigned CMD_FUNC_LSB  = 10;
   localparam int unsigned CMD_WDATA_LSB = 16;
   localparam int unsigned ST_BUSY_BIT   = 0;
   localparam int unsigned ST_ACK_BIT    = 1;
   localparam int unsigned ST_SLOT_LSB   = 4;
   localparam int unsigned ST_RDATA_LSB  = 8;
   localparam int unsigned ST_INTS_LSB   = 16;
   localparam int unsigned CFG_LOAD_BIT  = 0;
   localparam int unsigned CFG_LSLOT_LSB = 4;
   localparam int unsigned CFG_LADDR_LSB = 8;
   localparam int unsigned CFG_RADDR_LSB = 16;
   localparam logic [23:0] INT_MAP_RST   = 24'hfac688;

   localparam int unsigned IRQ_DONE      = 0;
   localparam int unsigned IRQ_LOST      = 1;
   localparam int unsigned IRQ_REFUSED   = 2;
   localparam int unsigned IRQ_TICK      = 3;
   localparam int unsigned IRQ_GRANT     = 4;
   localparam int unsigned IRQ_W         = 5;

   // ---------------------------------------------------------------
   // pin groups
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] slot_addr;
      logic [1:0] op_class;
      logic [3:0] function_code;
      logic [7:0] output_bus;
      logic       attention;
      logic       int_grant;
   } icbi_bus_out_t;

   typedef struct packed {
      logic       ack;
      logic       grant_taken;
      logic [7:0] int_req;
      logic [7:0] input_bus;
   } icbi_bus_in_t;

endpackage

// ==== rtl/icbi_tick.sv ====
module icbi_tick
  import icbi_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = TICK_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   output logic      tick
);
   import icbi_pkg::*;

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;

   // free running, no tie to instruction timing
   always_comb begin
      if (cnt_reg == 32'(PERIOD_CYC - 1)) begin
         cnt_next  = 32'h0;
         tick_next = 1'b1;
      end else begin
         cnt_next  = cnt_reg + 32'h1;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg  <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

   a_tick_single : assert property (@(posedge core_clk) disable iff (!rst_b)
      tick |=> !tick && cnt_reg == 32'h1)
      else $error("tick not a single pulse");

endmodule

// ==== rtl/icbi_top.sv ====
// Contract
// - eight request lines 0 to 7 reach every slot and tell which device wants service.
// - the processor drives a two-bit class: test 00, control 01, read 10, write 11.
// - attention is high for as long as an I/O instruction is in progress.
// - in program-load mode only the loading device is serviced.
// - input data comes back on an eight-bit input bus.
// - eight addressing lines go to every slot for address decode.
// - the periodic tick unit answers at fixed address 15.
// - the periodic tick runs freely at 15 Hz.
// - the refresh unit address is configurable and defaults to 8.
// - each slot's request line is chosen by configuration.
// - four function bits go out beside the class.
//
// Implementation choices: the address map and the APB interface to the registers.
module icbi_top
  import icbi_pkg::*;
#(
   parameter int unsigned TICK_PERIOD = TICK_CYC,
   parameter int unsigned ACK_WAIT    = ACK_WAIT_CYC
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   input  wire logic [11:0]             paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   output icbi_pkg::icbi_bus_out_t      bus_out,
   input  wire icbi_pkg::icbi_bus_in_t  bus_in,
   output logic                         refresh_sel,
   output logic                         irq
);
   import icbi_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_SETUP, S_WAIT, S_GRANT} icbi_state_t;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   icbi_bus_in_t pin_meta_reg;
   icbi_bus_in_t pin_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= '0;
         pin_reg      <= '0;
      end else begin
         pin_meta_reg <= bus_in;
         pin_reg      <= pin_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // tick source
   // ---------------------------------------------------------------
   logic tick;

   icbi_tick #(
      .PERIOD_CYC (TICK_PERIOD)
   ) u_tick (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .tick     (tick)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   icbi_state_t      state_reg,   state_next;
   logic [7:0]       addr_reg,    addr_next;
   logic [1:0]       op_reg,      op_next;
   logic [3:0]       func_reg,    func_next;
   logic [7:0]       wdata_reg,   wdata_next;
   logic [7:0]       rdata_reg,   rdata_next;
   logic             acked_reg,   acked_next;
   logic [2:0]       slot_reg,    slot_next;
   logic [7:0]       wait_reg,    wait_next;
   logic             tickp_reg,   tickp_next;
   logic             load_reg,    load_next;
   logic [2:0]       lslot_reg,   lslot_next;
   logic [7:0]       laddr_reg,   laddr_next;
   logic [7:0]       raddr_reg,   raddr_next;
   logic [23:0]      map_reg,     map_next;
   logic [IRQ_W-1:0] istat_reg,   istat_next;
   logic [IRQ_W-1:0] imask_reg,   imask_next;
   logic [31:0]      prdata_reg,  prdata_next;
   logic             pslverr_reg, pslverr_next;

   logic [IRQ_W-1:0] ev_set;
   logic [IRQ_W-1:0] ev_clr;
   logic [7:0]       slot_want;
   logic [2:0]       want_idx;
   logic             wr_acc;
   logic             setup_ph;
   logic             cmd_wr;
   logic             mapped;

   // ---------------------------------------------------------------
   // per-slot request decode
   // ---------------------------------------------------------------
   for (genvar s = 0; s < 8; s++) begin : g_slot
      // slot s listens on its configured line, only the loader in load mode
      assign slot_want[s] = pin_reg.int_req[map_reg[3*s +: 3]]
                            && (!load_reg || lslot_reg == 3'(s));
   end

   always_comb begin
      want_idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (slot_want[i]) begin
            want_idx = 3'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // apb access decode
   // ---------------------------------------------------------------
   assign setup_ph = psel && !penable;
   assign wr_acc   = psel && penable && pwrite;
   assign cmd_wr   = wr_acc && paddr == OFF_CMD;
   assign pready   = penable;

   always_comb begin
      mapped = 1'b1;
      prdata_next = prdata_reg;
      if (paddr == OFF_CMD) begin
         prdata_next = {8'h0, wdata_reg, 2'b0, func_reg, op_reg, addr_reg};
      end else if (paddr == OFF_STATUS) begin
         prdata_next = {8'h0, pin_reg.int_req, rdata_reg, 1'b0, slot_reg,
                        2'b0, acked_reg, state_reg != S_IDLE};
      end else if (paddr == OFF_CONFIG) begin
         prdata_next = {8'h0, raddr_reg, laddr_reg, 1'b0, lslot_reg, 3'b0, load_reg};
      end else if (paddr == OFF_INT_MAP) begin
         prdata_next = {8'h0, map_reg};
      end else if (paddr == OFF_IRQ_STAT) begin
         prdata_next = {27'h0, istat_reg};
      end else if (paddr == OFF_IRQ_MASK) begin
         prdata_next = {27'h0, imask_reg};
      end else begin
         mapped = 1'b0;
         prdata_next = 32'h0;
      end
      if (!setup_ph) begin
         prdata_next = prdata_reg;
      end
      pslverr_next = setup_ph ? !mapped : pslverr_reg;
   end

   // ---------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      addr_next  = addr_reg;
      op_next    = op_reg;
      func_next  = func_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      acked_next = acked_reg;
      slot_next  = slot_reg;
      wait_next  = wait_reg;
      tickp_next = tickp_reg | tick;
      ev_set     = '0;
      ev_set[IRQ_TICK] = tick;
      case (state_reg)
         S_IDLE: begin
            if (cmd_wr) begin
               if (load_reg && pwdata[CMD_ADDR_LSB +: 8] != laddr_reg) begin
                  ev_set[IRQ_REFUSED] = 1'b1;
               end else begin
                  addr_next  = pwdata[CMD_ADDR_LSB +: 8];
                  op_next    = pwdata[CMD_OP_LSB +: 2];
                  func_next  = pwdata[CMD_FUNC_LSB +: 4];
                  wdata_next = pwdata[CMD_WDATA_LSB +: 8];
                  acked_next = 1'b0;
                  wait_next  = 8'h0;
                  state_next = S_SETUP;
               end
            end else if (|slot_want) begin
               state_next = S_GRANT;
            end
         end
         S_SETUP: begin
            state_next = S_WAIT;
         end
         S_WAIT: begin
            wait_next = wait_reg + 8'h1;
            if (addr_reg == TICK_ADDR) begin
               rdata_next = {7'h0, tickp_reg};
               if (op_reg == OP_CONTROL) begin
                  tickp_next = tick;
               end
               acked_next = 1'b1;
               ev_set[IRQ_DONE] = 1'b1;
               state_next = S_IDLE;
            end else if (pin_reg.ack) begin
               if (op_reg == OP_READ || op_reg == OP_TEST) begin
                  rdata_next = pin_reg.input_bus;
               end
               acked_next = 1'b1;
               ev_set[IRQ_DONE] = 1'b1;
               state_next = S_IDLE;
            end else if (wait_reg == 8'(ACK_WAIT - 1)) begin
               ev_set[IRQ_LOST] = 1'b1;
               state_next = S_IDLE;
            end
         end
         S_GRANT: begin
            if (pin_reg.grant_taken) begin
               slot_next = want_idx;
               ev_set[IRQ_GRANT] = 1'b1;
               state_next = S_IDLE;
            end else if (!(|slot_want)) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // configuration and interrupt registers
   // ---------------------------------------------------------------
   always_comb begin
      load_next  = load_reg;
      lslot_next = lslot_reg;
      laddr_next = laddr_reg;
      raddr_next = raddr_reg;
      map_next   = map_reg;
      imask_next = imask_reg;
      ev_clr     = '0;
      if (wr_acc && paddr == OFF_CONFIG) begin
         load_next  = pwdata[CFG_LOAD_BIT];
         lslot_next = pwdata[CFG_LSLOT_LSB +: 3];
         laddr_next = pwdata[CFG_LADDR_LSB +: 8];
         raddr_next = pwdata[CFG_RADDR_LSB +: 8];
      end else if (wr_acc && paddr == OFF_INT_MAP) begin
         map_next   = pwdata[23:0];
      end else if (wr_acc && paddr == OFF_IRQ_STAT) begin
         ev_clr     = pwdata[IRQ_W-1:0];
      end else if (wr_acc && paddr == OFF_IRQ_MASK) begin
         imask_next = pwdata[IRQ_W-1:0];
      end
      // a new event beats its own clear
      istat_next = (istat_reg & ~ev_clr) | ev_set;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg   <= S_IDLE;
         addr_reg    <= 8'h0;
         op_reg      <= OP_TEST;
         func_reg    <= 4'h0;
         wdata_reg   <= 8'h0;
         rdata_reg   <= 8'h0;
         acked_reg   <= 1'b0;
         slot_reg    <= 3'h0;
         wait_reg    <= 8'h0;
         tickp_reg   <= 1'b0;
         load_reg    <= 1'b0;
         lslot_reg   <= LOAD_SLOT_RST;
         laddr_reg   <= LOAD_ADDR_RST;
         raddr_reg   <= REFRESH_RST;
         map_reg     <= INT_MAP_RST;
         istat_reg   <= '0;
         imask_reg   <= '0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         addr_reg    <= addr_next;
         op_reg      <= op_next;
         func_reg    <= func_next;
         wdata_reg   <= wdata_next;
         rdata_reg   <= rdata_next;
         acked_reg   <= acked_next;
         slot_reg    <= slot_next;
         wait_reg    <= wait_next;
         tickp_reg   <= tickp_next;
         load_reg    <= load_next;
         lslot_reg   <= lslot_next;
         laddr_reg   <= laddr_next;
         raddr_reg   <= raddr_next;
         map_reg     <= map_next;
         istat_reg   <= istat_next;
         imask_reg   <= imask_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata                = prdata_reg;
   assign pslverr               = pslverr_reg && penable;
   assign bus_out.slot_addr     = addr_reg;
   assign bus_out.op_class      = op_reg;
   assign bus_out.function_code = func_reg;
   assign bus_out.output_bus    = wdata_reg;
   assign bus_out.attention     = state_reg == S_SETUP || state_reg == S_WAIT;
   assign bus_out.int_grant     = state_reg == S_GRANT;
   assign refresh_sel           = bus_out.attention && addr_reg == raddr_reg;
   assign irq                   = |(istat_reg & imask_reg);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // last cycle at which a timed-out command may still hold attention
   localparam int LOST_HI = int'(ACK_WAIT);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_class_stable : assert property (
      bus_out.attention && $past(bus_out.attention)
      |-> $stable(bus_out.op_class) && $stable(bus_out.slot_addr))
      else $error("class or address moved during attention");
   a_attn_ends : assert property (
      state_reg == S_WAIT && pin_reg.ack |=> !bus_out.attention && acked_reg)
      else $error("attention held after acknowledge");
   a_load_refuse : assert property (
      state_reg == S_IDLE && cmd_wr && load_reg && pwdata[7:0] != laddr_reg
      |=> istat_reg[IRQ_REFUSED] && !bus_out.attention [*2])
      else $error("foreign device serviced in load mode");
   a_read_capture : assert property (
      state_reg == S_WAIT && pin_reg.ack && op_reg == OP_READ && addr_reg != TICK_ADDR
      |=> rdata_reg == $past(pin_reg.input_bus))
      else $error("input byte not captured");
   a_tick_answer : assert property (
      state_reg == S_SETUP && addr_reg == TICK_ADDR
      |=> ##1 state_reg == S_IDLE && acked_reg)
      else $error("tick address not answered");
   a_lost_bound : assert property (
      state_reg == S_SETUP |=> ##[1:LOST_HI] !bus_out.attention)
      else $error("ack wait not bounded");
   a_refresh_sel : assert property (
      refresh_sel |-> bus_out.attention && bus_out.slot_addr == raddr_reg)
      else $error("refresh select without match");
   a_grant_map : assert property (
      state_reg == S_GRANT && pin_reg.grant_taken
      |=> pin_reg.int_req[map_reg[3*slot_reg +: 3]] || $past(slot_want[want_idx]))
      else $error("granted slot not on its mapped line");
   a_func_drive : assert property (
      state_reg == S_IDLE && cmd_wr && !load_reg
      |=> bus_out.function_code == $past(pwdata[CMD_FUNC_LSB +: 4]) && bus_out.attention)
      else $error("function bits not driven");
   a_grant_hold : assert property (
      bus_out.int_grant && !pin_reg.grant_taken && (|slot_want) |=> bus_out.int_grant)
      else $error("grant dropped before taken");

   c_write_op : cover property (state_reg == S_WAIT && pin_reg.ack && op_reg == OP_WRITE);
   c_read_op  : cover property (state_reg == S_WAIT && pin_reg.ack && op_reg == OP_READ);
   c_grant    : cover property (state_reg == S_GRANT && pin_reg.grant_taken);
   c_lost     : cover property (ev_set[IRQ_LOST]);

endmodule

// ==== test/icbi_ctrl_model.sv ====
module icbi_ctrl_model
  import icbi_pkg::*;
#(
   parameter logic [7:0] MY_ADDR = 8'h05
) (
   input  wire logic                    core_clk,
   input  wire icbi_pkg::icbi_bus_out_t bus_out,
   input  wire logic                    want_service,
   input  wire logic [7:0]              rd_byte,
   output icbi_pkg::icbi_bus_in_t       bus_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_reg = 2'h0;
   logic [7:0] idle_reg = 8'h3c;
   logic       hit;
   // slow answer: ack only after three addressed cycles
   assign hit = bus_out.attention && (bus_out.slot_addr == MY_ADDR);
   always_ff @(posedge core_clk) begin
      wait_reg <= hit ? wait_reg + {1'b0, ~&wait_reg} : 2'h0;
      idle_reg <= ~idle_reg;
   end
   always_comb begin
      bus_in.ack         = hit && (wait_reg == 2'h3);
      bus_in.int_req     = {5'h00, want_service, 2'h0};
      bus_in.grant_taken = bus_out.int_grant && want_service;
      // released bus toggles every cycle
      bus_in.input_bus   = (hit && bus_out.op_class == OP_READ) ? rd_byte : idle_reg;
   end
endmodule

// ==== test/icbi_top_bench.sv ====
module icbi_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import icbi_pkg::*;
   logic          core_clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0;
   logic [31:0]   prdata;
   logic [31:0]   q;
   logic          pready, pslverr, refresh_sel, irq, err;
   logic          want_service = 1'b0;
   icbi_bus_out_t bus_out;
   icbi_bus_in_t  bus_in;
   int            n_mismatch = 0;
   int            samples_checked = 0;
   int            cyc = 0;
   icbi_top #(.TICK_PERIOD(20)) icbi_top_inst (.core_clk(core_clk), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_out(bus_out),
      .bus_in(bus_in), .refresh_sel(refresh_sel), .irq(irq));
   icbi_ctrl_model icbi_ctrl_model_inst (.core_clk(core_clk), .bus_out(bus_out),
      .want_service(want_service), .rd_byte(8'hc5), .bus_in(bus_in));
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] ad, input logic [1:0] op, input logic [3:0] fn,
                      input logic [7:0] wb);
      apb(1'b1, OFF_CMD, {8'h00, wb, 2'b00, fn, op, ad});
   endtask
   task automatic wait_idle();
      q = 32'h1;
      for (int i = 0; i < 100 && q[ST_BUSY_BIT] !== 1'b0; i++) apb(1'b0, OFF_STATUS, 32'h0);
   endtask
   task automatic t_reset();
      chk("attention", 32'h0, bus_out.attention);
      apb(1'b0, OFF_CONFIG, 32'h0);
      chk("config", 32'h00080110, q);
      apb(1'b0, OFF_INT_MAP, 32'h0);
      chk("int_map", {8'h00, INT_MAP_RST}, q);
   endtask
   task automatic t_read();
      apb(1'b1, OFF_IRQ_STAT, 32'h1f);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      cmd(8'h05, OP_READ, 4'ha, 8'h00);
      @(negedge core_clk);
      chk("slot_addr", 32'h05, bus_out.slot_addr);
      chk("function_code", 32'ha, bus_out.function_code);
      chk("attention", 32'h1, bus_out.attention);
      wait_idle();
      chk("read byte", 32'hc5, q[15:8]);
      @(negedge core_clk);
      chk("irq", 32'h1, irq);
      apb(1'b1, OFF_IRQ_STAT, 32'h1);
      @(negedge core_clk);
      chk("irq cleared", 32'h0, irq);
   endtask
   task automatic t_classes();
      for (int op = 0; op < 4; op++) begin
         cmd(8'h05, op[1:0], 4'h3, 8'h30 + op[7:0]);
         @(negedge core_clk);
         chk("op_class", op, bus_out.op_class);
         chk("output_bus", 32'h30 + op, bus_out.output_bus);
         wait_idle();
         chk("acked", 32'h1, q[ST_ACK_BIT]);
      end
   endtask
   task automatic t_tick();
      repeat (25) @(posedge core_clk);
      cmd(TICK_ADDR, OP_READ, 4'h0, 8'h00);
      wait_idle();
      chk("tick byte", 32'h01, q[15:8]);
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("tick irq", 32'h8, q & 32'ha);
   endtask
   task automatic t_empty();
      apb(1'b1, OFF_IRQ_STAT, 32'h1f);
      cmd(REFRESH_RST, OP_WRITE, 4'h0, 8'h11);
      @(negedge core_clk);
      chk("refresh_sel", 32'h1, refresh_sel);
      wait_idle();
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("lost", 32'h2, q & 32'h3);
   endtask
   task automatic t_load();
      apb(1'b1, OFF_CONFIG, 32'h00080111);
      cmd(8'h05, OP_READ, 4'h0, 8'h00);
      @(negedge core_clk);
      chk("load attention", 32'h0, bus_out.attention);
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("refused", 32'h4, q & 32'h4);
      apb(1'b1, OFF_CONFIG, 32'h00080110);
      apb(1'b0, 12'h020, 32'h0);
      chk("pslverr", 32'h1, err);
      chk("unmapped data", 32'h0, q);
   endtask
   task automatic t_grant();
      want_service <= 1'b1;
      for (int i = 0; i < 50 && bus_out.int_grant !== 1'b1; i++) @(negedge core_clk);
      chk("int_grant", 32'h1, bus_out.int_grant);
      repeat (8) @(posedge core_clk);
      want_service <= 1'b0;
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("granted slot", 32'h2, q[6:4]);
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("grant event", 32'h10, q & 32'h10);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_read();
      t_classes();
      t_tick();
      t_empty();
      t_load();
      t_grant();
      end_of_test();
   end
endmodule
